// File: hdl/cts_pkg.sv
// constants for the channel trigger sequencer
// Notes on behaviour
// RULE1 - immediate source goes straight to the delay stage on every pass
// RULE2 - reset and preset commands both select the immediate source
// RULE3 - timer source: first channel at once, later ones after the interval
// RULE4 - manual source waits for the step key, ignored while remote
// RULE5 - bus source waits for a bus trigger
// RULE6 - external source waits for the rear trigger input
// RULE7 - linked source waits for a trigger on the shared trigger line
// RULE8 - hold source ignores events until a force-immediate or force-signal command comes
// RULE9 - programmable delay after the event; reset and preset clear it
// RULE10 - bypass with external or linked source skips only the first wait
// RULE11 - force-immediate skips event wait and delay once
// RULE12 - force-signal skips event wait once but keeps the delay
// RULE13 - break before make, then relay settle plus extra settle time
// RULE14 - non-linked sources pulse channel-ready after each channel
// RULE15 - linked asynchronous mode pulses the output line after each channel
// RULE16 - semi-synchronous: release line, or pull low then release with bypass
// RULE17 - repeat from layer start until the channel count is used up
// RULE18 - automatic counting uses the scan list length
// RULE19 - reset sets count one; preset enables automatic counting
// RULE20 - remote only on listen addressing while remote enable is true
// RULE21 - remote ignores panel keys except local, which returns to local
// RULE22 - lockout ignores every panel key, local key included
// RULE23 - fixed output pulse width; infinite count wraps the scan list
package cts_pkg;
  localparam int unsigned CLK_MHZ           = 250;
  localparam int unsigned MS_CYCLES         = CLK_MHZ * 1000;
  localparam int unsigned TRIG_PULSE_NS     = 40;
  localparam int unsigned TRIG_PULSE_CYCLES = (TRIG_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RELAY_SETTLE_MS   = 3;
  localparam int unsigned TIME_W            = 30;
  localparam int unsigned COUNT_W           = 14;
  localparam int unsigned SRC_W             = 3;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_COUNT  = 8'h04;
  localparam logic [7:0] OFS_TIMER  = 8'h08;
  localparam logic [7:0] OFS_DELAY  = 8'h0C;
  localparam logic [7:0] OFS_SETTLE = 8'h10;
  localparam logic [7:0] OFS_LIST   = 8'h14;
  localparam logic [7:0] OFS_CMD    = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // control field positions
  localparam int unsigned CTRL_SRC_LSB  = 0;
  localparam int unsigned CTRL_BYPASS   = 3;
  localparam int unsigned CTRL_ASYNC    = 4;
  localparam int unsigned CTRL_AUTO     = 5;
  localparam int unsigned CTRL_INFINITE = 6;
  // command bits (write one)
  localparam int unsigned CMD_RESET     = 0;
  localparam int unsigned CMD_PRESET    = 1;
  localparam int unsigned CMD_FORCE_IMM = 2;
  localparam int unsigned CMD_FORCE_SIG = 3;
  localparam int unsigned CMD_BUS_TRIG  = 4;
  localparam int unsigned CMD_START     = 5;
  localparam int unsigned CMD_ABORT     = 6;
  // source codes
  localparam logic [2:0] SRC_IMM    = 3'h0;
  localparam logic [2:0] SRC_TIMER  = 3'h1;
  localparam logic [2:0] SRC_MANUAL = 3'h2;
  localparam logic [2:0] SRC_BUS    = 3'h3;
  localparam logic [2:0] SRC_EXT    = 3'h4;
  localparam logic [2:0] SRC_LINK   = 3'h5;
  localparam logic [2:0] SRC_HOLD   = 3'h6;
  // values after reset, and the count limit
  localparam logic [13:0] COUNT_RST  = 14'h0001;
  localparam logic [13:0] COUNT_MAX  = 14'h270F;
  localparam logic [29:0] TIMER_RST  = 30'h00000001;
  localparam logic [7:0]  LIST_RST   = 8'h01;
  typedef enum logic [2:0] {
    CTS_IDLE, CTS_EVENT, CTS_DELAY, CTS_BREAK, CTS_SETTLE, CTS_OUTPUT
  } cts_state_type;
endpackage

// File: hdl/cts_sequencer.sv
// channel layer trigger sequencer with apb register slave
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module cts_sequencer #(
  parameter int unsigned TICK_CYCLES = cts_pkg::MS_CYCLES,
  parameter int unsigned LIST_W      = 8
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       gpib_ren,
  input  wire logic                       gpib_listen_addr,
  input  wire logic                       gpib_llo,
  input  wire logic                       gpib_gtl,
  input  wire logic                       gpib_get,
  input  wire logic                       step_key,
  input  wire logic                       local_key,
  input  wire logic                       ext_trig_in,
  input  wire logic                       link_line_in,
  output logic                            link_line_out,
  output logic                            link_line_oe,
  output logic                            channel_ready,
  output logic                            relay_open,
  output logic                            relay_close,
  output logic      [LIST_W-1:0]          channel_index,
  output logic                            remote_state,
  output logic                            lockout_state
);
  import cts_pkg::*;

  localparam logic [31:0] TICK_LAST  = 32'(TICK_CYCLES - 1);
  localparam logic [7:0]  PULSE_LAST = 8'(TRIG_PULSE_CYCLES - 1);

  logic [SRC_W-1:0]   source_reg;
  logic               bypass_direction_select_reg;
  logic               async_mode_reg;
  logic               auto_count_reg;
  logic               infinite_reg;
  logic [COUNT_W-1:0] count_reg;
  logic [TIME_W-1:0]  timer_ms_reg;
  logic [TIME_W-1:0]  delay_ms_reg;
  logic [TIME_W-1:0]  extra_settle_time_reg;
  logic [LIST_W-1:0]  list_len_reg;
  cts_state_type      state_reg;
  cts_state_type      state_next;
  logic [31:0]        sub_reg;
  logic [TIME_W:0]    elapsed_reg;
  logic [31:0]        tsub_reg;
  logic [TIME_W:0]    telapsed_reg;
  logic               timer_first_reg;
  logic               first_pass_reg;
  logic               force_imm_reg;
  logic               force_sig_reg;
  logic               bus_trig_reg;
  logic [COUNT_W-1:0] remaining_reg;
  logic [7:0]         pulse_reg;
  logic               link_low_reg;
  logic               link_edge_reg;
  logic               link_prev_reg;

  logic               wr;
  logic               setup;
  logic               addr_ok;
  logic               cmd_wr;
  logic               tick;
  logic               ttick;
  logic               event_hit;
  logic               bypass_skip;
  logic               panel_ok;
  logic               is_link;
  logic [TIME_W:0]    settle_total;
  logic [COUNT_W-1:0] count_eff;
  logic               last_channel;

  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite;
  assign cmd_wr  = wr & (paddr == OFS_CMD);
  assign addr_ok = (paddr[1:0] == 2'h0) & (paddr <= OFS_STATUS);
  // zero wait states keep the master simple; data is staged in setup
  assign pready  = 1'b1;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~addr_ok;
      case (paddr)
        OFS_CTRL:   prdata <= {25'h0000000, infinite_reg, auto_count_reg, async_mode_reg,
                               bypass_direction_select_reg, source_reg};
        OFS_COUNT:  prdata <= {18'h00000, count_reg};
        OFS_TIMER:  prdata <= {2'h0, timer_ms_reg};
        OFS_DELAY:  prdata <= {2'h0, delay_ms_reg};
        OFS_SETTLE: prdata <= {2'h0, extra_settle_time_reg};
        OFS_LIST:   prdata <= 32'(list_len_reg);
        OFS_STATUS: prdata <= {8'(channel_index), 2'h0, remaining_reg[13:0] & 14'h3FFF,
                               lockout_state, remote_state, first_pass_reg, 1'b0,
                               1'b0, state_reg};
        default:    prdata <= 32'h00000000;
      endcase
    end
  end

  // configuration; reset and preset commands override a plain write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      source_reg                  <= SRC_IMM;
      bypass_direction_select_reg <= 1'b0;
      async_mode_reg              <= 1'b1;
      auto_count_reg              <= 1'b0;
      infinite_reg                <= 1'b0;
      count_reg                   <= COUNT_RST;
      timer_ms_reg                <= TIMER_RST;
      delay_ms_reg                <= '0;
      extra_settle_time_reg       <= '0;
      list_len_reg                <= LIST_W'(LIST_RST);
    end else if (cmd_wr & pwdata[CMD_RESET]) begin
      // RULE2 reset selects immediate
      source_reg     <= SRC_IMM;
      // RULE9 delay back to zero
      delay_ms_reg   <= '0;
      // RULE19 count becomes one
      count_reg      <= COUNT_RST;
      auto_count_reg <= 1'b0;
      infinite_reg   <= 1'b0;
    end else if (cmd_wr & pwdata[CMD_PRESET]) begin
      // RULE2 preset selects immediate
      source_reg     <= SRC_IMM;
      // RULE9 delay back to zero
      delay_ms_reg   <= '0;
      // RULE19 preset enables auto count
      auto_count_reg <= 1'b1;
    end else if (wr) begin
      case (paddr)
        OFS_CTRL: begin
          source_reg                  <= pwdata[CTRL_SRC_LSB +: SRC_W];
          bypass_direction_select_reg <= pwdata[CTRL_BYPASS];
          async_mode_reg              <= pwdata[CTRL_ASYNC];
          auto_count_reg              <= pwdata[CTRL_AUTO];
          infinite_reg                <= pwdata[CTRL_INFINITE];
        end
        OFS_COUNT: begin
          if (pwdata[COUNT_W-1:0] == '0) begin
            count_reg <= COUNT_RST;
          end else if (pwdata[31:0] > 32'(COUNT_MAX)) begin
            count_reg <= COUNT_MAX;
          end else begin
            count_reg <= pwdata[COUNT_W-1:0];
          end
        end
        // interval below one millisecond is raised to one
        OFS_TIMER:  timer_ms_reg <= (pwdata[TIME_W-1:0] == '0) ? TIMER_RST : pwdata[TIME_W-1:0];
        OFS_DELAY:  delay_ms_reg          <= pwdata[TIME_W-1:0];
        OFS_SETTLE: extra_settle_time_reg <= pwdata[TIME_W-1:0];
        OFS_LIST:   list_len_reg <= (pwdata[LIST_W-1:0] == '0) ? LIST_W'(LIST_RST)
                                                                : pwdata[LIST_W-1:0];
        default: ;
      endcase
    end
  end

  // remote and lockout front panel gating
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      remote_state  <= 1'b0;
      lockout_state <= 1'b0;
    end else begin
      if (!gpib_ren) begin
        remote_state  <= 1'b0;
        lockout_state <= 1'b0;
      end else begin
        // RULE20 remote on listen address
        if (gpib_listen_addr) begin
          remote_state <= 1'b1;
        // RULE21 local key returns local
        end else if (gpib_gtl | (local_key & ~lockout_state)) begin
          remote_state <= 1'b0;
        end
        // RULE22 lockout kills local key
        if (gpib_llo) begin
          lockout_state <= 1'b1;
        end
      end
    end
  end

  // RULE4 step key gated by remote
  assign panel_ok = ~remote_state & ~lockout_state;
  assign is_link  = (source_reg == SRC_LINK);

  // falling edge on the shared line is an incoming trigger
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      link_prev_reg <= 1'b1;
      link_edge_reg <= 1'b0;
    end else begin
      link_prev_reg <= link_line_in;
      link_edge_reg <= link_prev_reg & ~link_line_in & ~link_line_oe;
    end
  end

  // one-shot software requests; a new request beats the consume
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      force_imm_reg <= 1'b0;
      force_sig_reg <= 1'b0;
      bus_trig_reg  <= 1'b0;
    end else begin
      if (cmd_wr & pwdata[CMD_FORCE_IMM]) begin
        force_imm_reg <= 1'b1;
      end else if (state_reg == CTS_EVENT && force_imm_reg) begin
        force_imm_reg <= 1'b0;
      end
      if (cmd_wr & pwdata[CMD_FORCE_SIG]) begin
        force_sig_reg <= 1'b1;
      end else if (state_reg == CTS_EVENT && force_sig_reg && !force_imm_reg) begin
        force_sig_reg <= 1'b0;
      end
      // RULE5 bus trigger from get or command
      if (gpib_get | (cmd_wr & pwdata[CMD_BUS_TRIG])) begin
        bus_trig_reg <= 1'b1;
      end else if (state_reg != CTS_EVENT || event_hit) begin
        bus_trig_reg <= 1'b0;
      end
    end
  end

  // millisecond base restarting on every state change
  assign tick = (sub_reg == TICK_LAST);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sub_reg     <= '0;
      elapsed_reg <= '0;
    end else if (state_next != state_reg) begin
      sub_reg     <= '0;
      elapsed_reg <= '0;
    end else if (tick) begin
      sub_reg     <= '0;
      elapsed_reg <= elapsed_reg + 1'b1;
    end else begin
      sub_reg <= sub_reg + 32'h00000001;
    end
  end

  // RULE3 interval timer spans passes
  assign ttick = (tsub_reg == TICK_LAST);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tsub_reg     <= '0;
      telapsed_reg <= '0;
    end else if (state_reg == CTS_EVENT && state_next != CTS_EVENT) begin
      tsub_reg     <= '0;
      telapsed_reg <= '0;
    end else if (ttick) begin
      tsub_reg <= '0;
      if (!telapsed_reg[TIME_W]) begin
        telapsed_reg <= telapsed_reg + 1'b1;
      end
    end else begin
      tsub_reg <= tsub_reg + 32'h00000001;
    end
  end

  // RULE10 bypass only on first pass
  assign bypass_skip = bypass_direction_select_reg & first_pass_reg &
                       ((source_reg == SRC_EXT) | is_link);

  always_comb begin
    case (source_reg)
      // RULE1 immediate never waits
      SRC_IMM:    event_hit = 1'b1;
      // RULE3 first channel without waiting
      SRC_TIMER:  event_hit = timer_first_reg | (telapsed_reg >= {1'b0, timer_ms_reg});
      SRC_MANUAL: event_hit = step_key & panel_ok;
      SRC_BUS:    event_hit = bus_trig_reg;
      // RULE6 rear trigger input
      SRC_EXT:    event_hit = ext_trig_in;
      // RULE7 shared line trigger
      SRC_LINK:   event_hit = link_edge_reg;
      // RULE8 hold waits for a force command only
      default:    event_hit = 1'b0;
    endcase
  end

  assign settle_total = (TIME_W+1)'(RELAY_SETTLE_MS) + {1'b0, extra_settle_time_reg};
  // RULE18 auto count from list
  assign count_eff    = auto_count_reg ? COUNT_W'(list_len_reg) : count_reg;
  assign last_channel = ~infinite_reg & (remaining_reg <= 14'h0001);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CTS_IDLE: begin
        if (cmd_wr & pwdata[CMD_START]) begin
          state_next = CTS_EVENT;
        end
      end
      CTS_EVENT: begin
        // RULE11 force immediate skips delay
        if (force_imm_reg) begin
          state_next = CTS_BREAK;
        // RULE12 force signal keeps delay
        end else if (force_sig_reg | bypass_skip | event_hit) begin
          state_next = CTS_DELAY;
        end
      end
      // RULE9 programmed delay
      CTS_DELAY: begin
        if (elapsed_reg >= {1'b0, delay_ms_reg}) begin
          state_next = CTS_BREAK;
        end
      end
      CTS_BREAK:  state_next = CTS_SETTLE;
      // RULE13 relay plus extra settle
      CTS_SETTLE: begin
        if (elapsed_reg >= settle_total) begin
          state_next = CTS_OUTPUT;
        end
      end
      CTS_OUTPUT: begin
        if (pulse_reg == PULSE_LAST) begin
          // RULE17 repeat until count done
          state_next = last_channel ? CTS_IDLE : CTS_EVENT;
        end
      end
      default: state_next = CTS_IDLE;
    endcase
    if (cmd_wr & pwdata[CMD_ABORT]) begin
      state_next = CTS_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= CTS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // pass bookkeeping: count, first pass, scan position
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      remaining_reg   <= '0;
      first_pass_reg  <= 1'b0;
      timer_first_reg <= 1'b0;
      channel_index   <= '0;
    end else if (state_reg == CTS_IDLE && state_next == CTS_EVENT) begin
      remaining_reg   <= count_eff;
      // RULE10 re-armed on layer entry
      first_pass_reg  <= 1'b1;
      timer_first_reg <= 1'b1;
      channel_index   <= '0;
    end else if (state_reg == CTS_EVENT && state_next != CTS_EVENT) begin
      first_pass_reg  <= 1'b0;
      timer_first_reg <= 1'b0;
    end else if (state_reg == CTS_OUTPUT && state_next == CTS_EVENT) begin
      remaining_reg <= remaining_reg - 14'h0001;
      // RULE23 wrap at end of list
      if (channel_index >= list_len_reg - 1'b1) begin
        channel_index <= '0;
      end else begin
        channel_index <= channel_index + 1'b1;
      end
    end
  end

  // RULE13 open before close
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      relay_open  <= 1'b0;
      relay_close <= 1'b0;
    end else begin
      relay_open  <= (state_reg == CTS_DELAY || state_reg == CTS_EVENT) &&
                     state_next == CTS_BREAK;
      relay_close <= (state_reg == CTS_BREAK);
    end
  end

  // output trigger shaping; width is fixed so downstream can count on it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pulse_reg     <= '0;
      channel_ready <= 1'b0;
      link_low_reg  <= 1'b0;
    end else begin
      if (state_reg == CTS_OUTPUT && pulse_reg != PULSE_LAST) begin
        pulse_reg <= pulse_reg + 8'h01;
      end else begin
        pulse_reg <= '0;
      end
      // RULE14 channel ready pulse
      channel_ready <= (state_next == CTS_OUTPUT) && !is_link;
      if (state_next == CTS_OUTPUT && is_link) begin
        // RULE15 async link pulse
        // RULE16 semi-sync low only with bypass
        link_low_reg <= async_mode_reg | bypass_direction_select_reg;
      // RULE16 semi-sync held low while switching
      end else if (is_link && !async_mode_reg &&
                   (state_next == CTS_BREAK || state_next == CTS_SETTLE)) begin
        link_low_reg <= 1'b1;
      end else begin
        link_low_reg <= 1'b0;
      end
    end
  end

  // open drain: only ever drive low
  assign link_line_out = 1'b0;
  assign link_line_oe  = link_low_reg;
endmodule // cts_sequencer

// File: tb/cts_sequencer_asserts.sv
// checker for the channel trigger sequencer ports
`timescale 1ns/1ps
module cts_sequencer_asserts (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic gpib_ren,
  input wire logic gpib_listen_addr,
  input wire logic gpib_llo,
  input wire logic gpib_gtl,
  input wire logic local_key,
  input wire logic relay_open,
  input wire logic relay_close,
  input wire logic channel_ready,
  input wire logic remote_state,
  input wire logic lockout_state
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_ready_hi;
    channel_ready [*8] ##1 channel_ready [*2] ##1 !channel_ready;
  endsequence
  sequence s_break_make;
    relay_close ##0 !relay_open;
  endsequence
  AST_BREAK_MAKE: assert property (relay_open |=> s_break_make)
    else $error("close did not follow open");
  AST_OPEN_ONE: assert property (relay_open |=> !relay_open)
    else $error("open pulse too long");
  AST_SETTLE_GAP: assert property (relay_close |=> !channel_ready [*8])
    else $error("ready before settling");
  AST_READY_WIDTH: assert property ($rose(channel_ready) |-> s_ready_hi)
    else $error("ready pulse width wrong");
  AST_REMOTE_ENTRY: assert property ($rose(remote_state) |->
    $past(gpib_listen_addr) && $past(gpib_ren))
    else $error("remote without listen addressing");
  AST_REN_DROP: assert property (!gpib_ren |=> !remote_state && !lockout_state)
    else $error("remote kept without ren");
  AST_LOCAL_KEY: assert property (remote_state && !lockout_state && local_key
    && !gpib_listen_addr && !gpib_llo |=> !remote_state)
    else $error("local key ignored");
  AST_LOCKOUT_HOLD: assert property (remote_state && lockout_state && gpib_ren
    && !gpib_gtl |=> remote_state)
    else $error("lockout left remote");
  AST_LOCKOUT_ENTRY: assert property ($rose(lockout_state) |-> $past(gpib_llo))
    else $error("lockout without llo");
endmodule // cts_sequencer_asserts
bind cts_sequencer cts_sequencer_asserts u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .gpib_ren(gpib_ren), .gpib_listen_addr(gpib_listen_addr), .gpib_llo(gpib_llo),
  .gpib_gtl(gpib_gtl), .local_key(local_key), .relay_open(relay_open),
  .relay_close(relay_close), .channel_ready(channel_ready),
  .remote_state(remote_state), .lockout_state(lockout_state));

// File: tb/cts_partner.sv
// far side model: bus controller, panel keys, trigger sources, shared line
`timescale 1ns/1ps
module cts_partner (
  input  wire logic clk_sys,
  input  wire logic link_line_out,
  input  wire logic link_line_oe,
  output logic      gpib_ren,
  output logic      gpib_listen_addr,
  output logic      gpib_llo,
  output logic      gpib_gtl,
  output logic      gpib_get,
  output logic      ext_trig_in,
  output logic      step_key,
  output logic      local_key,
  output logic      link_line_in
);
  logic       peer_low;
  // pulled-up line, any party may hold it low
  assign link_line_in = !((link_line_oe && !link_line_out) || peer_low);
  initial begin
    {gpib_listen_addr, peer_low, local_key, step_key} = 4'h0;
    {ext_trig_in, gpib_get, gpib_gtl, gpib_llo} = 4'h0;
    gpib_ren = 1'b0;
  end
  task automatic drive(input int i, input logic v);
    case (i)
      0: gpib_llo <= v;
      1: gpib_gtl <= v;
      2: gpib_get <= v;
      3: ext_trig_in <= v;
      4: step_key <= v;
      5: local_key <= v;
      6: peer_low <= v;
      default: gpib_listen_addr <= v;
    endcase
  endtask
  task automatic fire(input int i);
    @(posedge clk_sys) drive(i, 1'b1);
    @(posedge clk_sys) drive(i, 1'b0);
  endtask
  task automatic ren(input logic v);
    @(posedge clk_sys) gpib_ren <= v;
  endtask
endmodule // cts_partner

// File: tb/cts_sequencer_tb.sv
// testbench for the channel trigger sequencer
`timescale 1ns/1ps
module cts_sequencer_tb;
  import cts_pkg::*;
  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, channel_index;
  logic [31:0] pwdata, prdata, rd;
  logic        gpib_ren, gpib_listen_addr, gpib_llo, gpib_gtl, gpib_get, step_key;
  logic        local_key, ext_trig_in, link_line_in, link_line_out, link_line_oe;
  logic        channel_ready, relay_open, relay_close, remote_state, lockout_state;
  int          fail_count, checked, cyc, n_cl, n_rd, n_oe, t_cl, t_pr, b_cl, b_rd, b_oe, t0;
  logic [2:0]  srcs [4] = '{SRC_BUS, SRC_EXT, SRC_MANUAL, SRC_LINK};
  int          fires [4] = '{2, 3, 4, 6};
  // short tick keeps millisecond times small
  cts_sequencer #(.TICK_CYCLES(10)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpib_ren(gpib_ren),
    .gpib_listen_addr(gpib_listen_addr), .gpib_llo(gpib_llo), .gpib_gtl(gpib_gtl),
    .gpib_get(gpib_get), .step_key(step_key), .local_key(local_key),
    .ext_trig_in(ext_trig_in), .link_line_in(link_line_in),
    .link_line_out(link_line_out), .link_line_oe(link_line_oe),
    .channel_ready(channel_ready), .relay_open(relay_open), .relay_close(relay_close),
    .channel_index(channel_index), .remote_state(remote_state),
    .lockout_state(lockout_state));
  cts_partner p (.clk_sys(clk_sys), .link_line_out(link_line_out),
    .link_line_oe(link_line_oe), .gpib_ren(gpib_ren), .gpib_listen_addr(gpib_listen_addr),
    .gpib_llo(gpib_llo), .gpib_gtl(gpib_gtl), .gpib_get(gpib_get),
    .ext_trig_in(ext_trig_in), .step_key(step_key), .local_key(local_key),
    .link_line_in(link_line_in));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (relay_close) begin
      n_cl <= n_cl + 1;
      t_pr <= t_cl;
      t_cl <= cyc;
    end
    if ($rose(channel_ready)) n_rd <= n_rd + 1;
    if ($rose(link_line_oe)) n_oe <= n_oe + 1;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s expected %0h seen %0h", n, e, g);
      fail_count++;
    end
  endtask
  // one idle edge first so psel is never set twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys) penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic start(input logic [31:0] c);
    wr(OFS_CTRL, c);
    b_cl = n_cl;
    b_rd = n_rd;
    b_oe = n_oe;
    wr(OFS_CMD, 32'h20);
  endtask
  task automatic done(input int cl, input int rdy, input int oe);
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      k++;
    end while (rd[2:0] !== 3'h0 && k < 500);
    if (k >= 500) begin
      fail_count++;
      print_verdict();
    end
    chk("closes", cl, n_cl - b_cl);
    chk("ready pulses", rdy, n_rd - b_rd);
    chk("link pulses", oe, n_oe - b_oe);
    $display("test ended at cycle %0d", cyc);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdchk("ctrl", OFS_CTRL, 32'h10);
    rdchk("count", OFS_COUNT, 32'h1);
    rdchk("delay", OFS_DELAY, 32'h0);
    rdchk("unmapped", 8'h20, 32'h0);
    chk("slverr", 1, err);
    for (int i = 0; i < 4; i++) begin
      start({27'h0, 1'b1, 1'b0, srcs[i]});
      idle(40);
      chk("early close", 0, n_cl - b_cl);
      p.fire(fires[i]);
      done(1, 32'(i < 3), 32'(i == 3));
    end
    wr(OFS_DELAY, 32'h5);
    for (int j = 0; j < 2; j++) begin
      start(32'h16);
      p.fire(3);
      idle(40);
      chk("hold close", 0, n_cl - b_cl);
      t0 = cyc;
      wr(OFS_CMD, j ? 32'h8 : 32'h4);
      done(1, 1, 0);
      chk("delayed", j, 32'((t_cl - t0) >= 50));
    end
    wr(OFS_CMD, 32'h2);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("preset ctrl", 32'h20, rd & 32'h27);
    rdchk("preset delay", OFS_DELAY, 32'h0);
    wr(OFS_LIST, 32'h3);
    start(32'h30);
    done(3, 3, 0);
    chk("index", 2, channel_index);
    wr(OFS_COUNT, 32'h2);
    wr(OFS_TIMER, 32'hA);
    t0 = cyc;
    start(32'h11);
    done(2, 2, 0);
    chk("first timer", 1, 32'((t_pr - t0) < 30));
    chk("timer gap", 1, 32'((t_cl - t_pr) >= 100));
    start(32'h1C);
    idle(80);
    chk("bypass pass", 1, n_cl - b_cl);
    p.fire(3);
    done(2, 2, 0);
    wr(OFS_CMD, 32'h1);
    rdchk("reset count", OFS_COUNT, 32'h1);
    p.ren(1'b1);
    idle(3);
    chk("ren only", 0, remote_state);
    p.fire(7);
    idle(2);
    chk("remote", 1, remote_state);
    start(32'h12);
    p.fire(4);
    idle(40);
    chk("remote step", 0, n_cl - b_cl);
    p.fire(5);
    idle(2);
    chk("local key", 0, remote_state);
    p.fire(4);
    done(1, 1, 0);
    p.fire(7);
    p.fire(0);
    p.fire(5);
    idle(2);
    chk("lockout", 1, remote_state);
    p.fire(1);
    idle(2);
    chk("gtl", 0, remote_state);
    p.ren(1'b0);
    idle(2);
    chk("ren off", 0, lockout_state);
    print_verdict();
  end
endmodule // cts_sequencer_tb
